/* verilog/udc_pkg.sv */
package udc_pkg;

   // ----------------------------------------------------------------
   // Counter geometry
   // ----------------------------------------------------------------
   localparam int         UDC_WIDTH     = 4;
   localparam logic [3:0] UDC_STATE_MAX = 4'hF;
   localparam logic [3:0] UDC_STATE_MIN = 4'h0;
   localparam logic [3:0] UDC_STATE_RST = 4'h0;

   // ----------------------------------------------------------------
   // Register map, byte addresses of aligned 32-bit words
   // ----------------------------------------------------------------
   localparam int         UDC_ADDR_W     = 4;
   localparam logic [3:0] UDC_OFS_CONTROL = 4'h0;
   localparam logic [3:0] UDC_OFS_PRESET  = 4'h4;
   localparam logic [3:0] UDC_OFS_STATUS  = 4'h8;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int UDC_CTRL_LOAD_N_BIT = 0;
   localparam int UDC_CTRL_CEP_N_BIT  = 1;
   localparam int UDC_CTRL_CET_N_BIT  = 2;
   localparam int UDC_CTRL_UP_BIT     = 3;
   localparam int UDC_STAT_TC_N_BIT   = 4;

   localparam logic [3:0] UDC_CTRL_RST   = 4'hF;
   localparam logic [3:0] UDC_PRESET_RST = 4'h0;

   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0] UDC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] UDC_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic load_strobe_n;
      logic parallel_count_enable_n;
      logic trickle_count_enable_n;
      logic count_up;
   } udc_ctrl_t;

   typedef enum logic [1:0] {
      UDC_SEL_CONTROL,
      UDC_SEL_PRESET,
      UDC_SEL_STATUS,
      UDC_SEL_NONE
   } udc_sel_t;

   // ----------------------------------------------------------------
   // Shared arithmetic
   // ----------------------------------------------------------------
   function automatic logic [3:0] udc_step(input logic [3:0] s, input logic up);
      return up ? 4'(s + 4'h1) : 4'(s - 4'h1);
   endfunction

   function automatic logic udc_tc_n(input logic [3:0] s, input logic cet_n, input logic up);
      return !(!cet_n && ((up && s == UDC_STATE_MAX) || (!up && s == UDC_STATE_MIN)));
   endfunction

endpackage

/* verilog/udc_counter_core.sv */
`timescale 1ns/1ps
`default_nettype none
module udc_counter_core (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire udc_pkg::udc_ctrl_t ctrl,
   input  wire logic [3:0]         preset_data,
   output var  logic [3:0]         count_state,
   output var  logic               terminal_count_n
);
   import udc_pkg::*;

   logic [3:0] next_count_state;
   logic       next_terminal_count_n;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_count_state = count_state;
      if (!ctrl.load_strobe_n) begin
         next_count_state = preset_data;
      end else if (!ctrl.parallel_count_enable_n && !ctrl.trickle_count_enable_n) begin
         // Wraps naturally at 4 bits; every code is legal
         next_count_state = udc_step(count_state, ctrl.count_up);
      end
      // Flag decoded from the new state so it never lags the count
      next_terminal_count_n = udc_tc_n(next_count_state, ctrl.trickle_count_enable_n,
                                       ctrl.count_up);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_state      <= UDC_STATE_RST;
         terminal_count_n <= 1'b1;
      end else begin
         count_state      <= next_count_state;
         terminal_count_n <= next_terminal_count_n;
      end
   end

endmodule // udc_counter_core
`default_nettype wire

/* verilog/udc_up_down_counter.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - The count is four bits and wraps 15 to 0 going up and 0 to 15 going down.
// - Count and load changes happen only on the rising clock edge.
// - A load request beats counting and holding, ignoring enables and direction.
// - While the load strobe is low the preset data is copied in at the next edge.
// - Counting needs both enables low and no load; otherwise the count holds.
// - The direction select seen at the edge picks increment or decrement.
// - Terminal count idles high and is low only with trickle enable low at 15 up or 0 down.
// - Terminal count ignores the parallel enable.
// - Every 4-bit code is a legal state, so there is no illegal state to recover from.
//
module udc_up_down_counter #(
   parameter int ADDR_W = udc_pkg::UDC_ADDR_W
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output var  logic [3:0]        count_state,
   output var  logic              terminal_count_n
);
   import udc_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Byte offset bits below the word are ignored
   function automatic udc_sel_t udc_decode(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] word;
      word = {a[ADDR_W-1:2], 2'b00};
      if (word == ADDR_W'(UDC_OFS_CONTROL)) return UDC_SEL_CONTROL;
      if (word == ADDR_W'(UDC_OFS_PRESET))  return UDC_SEL_PRESET;
      if (word == ADDR_W'(UDC_OFS_STATUS))  return UDC_SEL_STATUS;
      return UDC_SEL_NONE;
   endfunction

   // ----------------------------------------------------------------
   // Software-visible state
   // ----------------------------------------------------------------
   logic [3:0]        control;
   logic [3:0]        preset;
   logic [3:0]        next_control;
   logic [3:0]        next_preset;
   udc_ctrl_t         ctrl;

   // ----------------------------------------------------------------
   // Write channel state
   // ----------------------------------------------------------------
   logic              aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic              w_held;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              next_aw_held;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              next_w_held;
   logic [31:0]       next_w_data;
   logic [3:0]        next_w_strb;
   logic              next_awready;
   logic              next_wready;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   udc_sel_t          wsel;

   // ----------------------------------------------------------------
   // Read channel state
   // ----------------------------------------------------------------
   logic              next_arready;
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic [3:0]        core_state;
   logic              core_tc_n;

   assign ctrl = '{load_strobe_n:           control[UDC_CTRL_LOAD_N_BIT],
                   parallel_count_enable_n: control[UDC_CTRL_CEP_N_BIT],
                   trickle_count_enable_n:  control[UDC_CTRL_CET_N_BIT],
                   count_up:                control[UDC_CTRL_UP_BIT]};

   // ----------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------
   // Address and data may come in either order; commit is one edge
   // after both are held, which keeps the decode off the input path
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_control = control;
      next_preset  = preset;
      wsel         = udc_decode(aw_addr);
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = UDC_RESP_OKAY;
         case (wsel)
            UDC_SEL_CONTROL: begin
               if (w_strb[0]) begin
                  next_control = w_data[3:0];
               end
            end
            UDC_SEL_PRESET: begin
               if (w_strb[0]) begin
                  next_preset = w_data[3:0];
               end
            end
            UDC_SEL_STATUS: begin
               next_bresp = UDC_RESP_OKAY;
            end
            default: begin
               next_bresp = UDC_RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         w_held        <= 1'b0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= UDC_RESP_OKAY;
         control       <= UDC_CTRL_RST;
         preset        <= UDC_PRESET_RST;
      end else begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         control       <= next_control;
         preset        <= next_preset;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = UDC_RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (udc_decode(s_axi_araddr))
            UDC_SEL_CONTROL: begin
               next_rdata[3:0] = control;
            end
            UDC_SEL_PRESET: begin
               next_rdata[3:0] = preset;
            end
            UDC_SEL_STATUS: begin
               next_rdata[3:0]               = core_state;
               next_rdata[UDC_STAT_TC_N_BIT] = core_tc_n;
            end
            default: begin
               next_rresp = UDC_RESP_SLVERR;
            end
         endcase
      end
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= UDC_RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Flag is a registered decode, so it is glitch free here even
   // though downstream logic should still not clock from it
   udc_counter_core u_core (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .ctrl             (ctrl),
      .preset_data      (preset),
      .count_state      (core_state),
      .terminal_count_n (core_tc_n)
   );

   assign count_state      = core_state;
   assign terminal_count_n = core_tc_n;

endmodule // udc_up_down_counter
`default_nettype wire

/* dv/udc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module udc_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [3:0]  count_state,
   input wire logic        terminal_count_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   import udc_pkg::*;
   logic [3:0] aw_q;
   logic [3:0] wd_q;
   logic [3:0] ctl_m;
   logic [3:0] pre_m;
   logic       ws_q;
   logic       bv_q;
   // Shadow of control and preset, updated one edge after the design's
   // copy: that is exactly the word the counter used one edge earlier
   always @(posedge aclk) begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
         wd_q <= s_axi_wdata[3:0];
         ws_q <= s_axi_wstrb[0];
      end
      if (!aresetn) begin
         ctl_m <= UDC_CTRL_RST;
         pre_m <= UDC_PRESET_RST;
      end else if (s_axi_bvalid && !bv_q && ws_q) begin
         if (aw_q[3:2] == UDC_OFS_CONTROL[3:2]) ctl_m <= wd_q;
         if (aw_q[3:2] == UDC_OFS_PRESET[3:2]) pre_m <= wd_q;
      end
   end
   function automatic logic [3:0] exp_next(input logic [3:0] c, input logic [3:0] k,
                                           input logic [3:0] pv);
      if (!k[UDC_CTRL_LOAD_N_BIT]) return pv;
      if (k[UDC_CTRL_CEP_N_BIT] || k[UDC_CTRL_CET_N_BIT]) return c;
      return k[UDC_CTRL_UP_BIT] ? 4'(c + 4'h1) : 4'(c - 4'h1);
   endfunction
   function automatic logic exp_tc_n(input logic [3:0] c, input logic [3:0] k);
      return !(!k[UDC_CTRL_CET_N_BIT] &&
               (k[UDC_CTRL_UP_BIT] ? c == UDC_STATE_MAX : c == UDC_STATE_MIN));
   endfunction
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_wr_lat;
      s_wr_taken |=> s_b_late;
   endproperty
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_b_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_tc_decode;
      !terminal_count_n |-> count_state == 4'hF || count_state == 4'h0;
   endproperty
   property p_rst;
      disable iff (1'b0)
      !aresetn |=> count_state == 4'h0 && terminal_count_n && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   property p_count_step;
      count_state == exp_next($past(count_state), ctl_m, pre_m);
   endproperty
   property p_tc_exact;
      terminal_count_n == exp_tc_n(count_state, ctl_m);
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_b_busy: assert property (p_b_busy) else $error("ready during write answer");
   a_tc_decode: assert property (p_tc_decode) else $error("flag low off boundary");
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_count_step: assert property (p_count_step) else $error("count step wrong");
   a_tc_exact: assert property (p_tc_exact) else $error("flag wrong for count");
endmodule // udc_monitor
`default_nettype wire

/* dv/udc_cascade_stage.sv */
`timescale 1ns/1ps
`default_nettype none
// Next stage of a chain; flag used as an enable, never as a clock
module udc_cascade_stage (
   input wire logic  aclk,
   input wire logic  aresetn,
   input wire logic  carry_in_n,
   input wire logic  enable_n,
   input wire logic  up,
   output var logic [3:0] high_count
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_count <= 4'h0;
      end else if (!enable_n && !carry_in_n) begin
         high_count <= up ? 4'(high_count + 4'h1) : 4'(high_count - 4'h1);
      end
   end
endmodule // udc_cascade_stage
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import udc_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, casc_en_n = 1, casc_up = 1;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] count_state, high_count, p;
   logic [3:0] wr_strb = 4'hF;
   logic terminal_count_n;
   int num_errors = 0, num_checks = 0, cyc = 0, seed = 31298;
   udc_up_down_counter dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_state, .terminal_count_n);
   udc_cascade_stage casc_u (.aclk, .aresetn, .carry_in_n(terminal_count_n),
      .enable_n(casc_en_n), .up(casc_up), .high_count);
   always #50 aclk = ~aclk;
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ------------------------------
   // Checks and bus cycles
   // ------------------------------
   task automatic print_verdict;
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t response %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic tc_exp(input logic [3:0] c, input logic cet_n, input logic up);
      return !(!cet_n && (up ? c == 4'hF : c == 4'h0));
   endfunction
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= wr_strb;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Controls steady; the cascade stage counts along as the high nibble
   task automatic run(input int n, input logic cep_n, input logic cet_n, input logic up);
      logic [3:0] c;
      logic [3:0] h;
      @(posedge aclk);
      casc_en_n <= cep_n;
      casc_up <= up;
      @(negedge aclk);
      c = count_state;
      h = high_count;
      repeat (n) begin
         @(negedge aclk);
         if (!cep_n && !tc_exp(c, cet_n, up)) h = up ? 4'(h + 4'h1) : 4'(h - 4'h1);
         if (!cep_n && !cet_n) c = up ? 4'(c + 4'h1) : 4'(c - 4'h1);
         chk_val(32'(count_state), 32'(c));
         chk_val(32'(terminal_count_n), 32'(tc_exp(c, cet_n, up)));
         chk_val(32'(high_count), 32'(h));
      end
      @(posedge aclk);
      casc_en_n <= 1;
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      axi_rd(UDC_OFS_CONTROL, rd, rr);
      chk_val(rd, 32'h0000_000F);
      axi_rd(UDC_OFS_PRESET, rd, rr);
      chk_val(rd, 32'h0000_0000);
      axi_rd(UDC_OFS_STATUS, rd, rr);
      chk_val(rd, 32'h0000_0010);
      axi_rd(4'hC, rd, rr);
      chk_resp(rr, UDC_RESP_SLVERR);
      chk_val(rd, 32'h0000_0000);
      axi_wr(4'hC, 32'h0000_0001, rr);
      chk_resp(rr, UDC_RESP_SLVERR);
      axi_wr(UDC_OFS_STATUS, 32'h0000_0005, rr);
      chk_resp(rr, UDC_RESP_OKAY);
      // Cleared byte strobe: write answered but ignored
      wr_strb = 4'h0;
      axi_wr(UDC_OFS_PRESET, 32'h0000_0005, rr);
      wr_strb = 4'hF;
      chk_resp(rr, UDC_RESP_OKAY);
      axi_rd(UDC_OFS_PRESET, rd, rr);
      chk_val(rd, 32'h0000_0000);
      // Load beats counting: both enables on while loading
      for (int i = 0; i < 6; i++) begin
         p = (i < 2) ? 4'hF : (i < 4) ? 4'h0 : 4'($random(seed));
         axi_wr(UDC_OFS_PRESET, {28'h0, p}, rr);
         axi_wr(UDC_OFS_CONTROL, {28'h0, i[0], 3'b000}, rr);
         axi_rd(UDC_OFS_STATUS, rd, rr);
         chk_val(rd, {27'h0, tc_exp(p, 1'b0, i[0]), p});
      end
      // Every enable and direction mode, from a random preset, or a boundary one when only trickle enable is on
      for (int m = 0; m < 8; m++) begin
         // Parallel enable off at the boundary: flag must still go low
         p = (m[1:0] == 2'b01) ? {4{m[2]}} : 4'($random(seed));
         axi_wr(UDC_OFS_PRESET, {28'h0, p}, rr);
         axi_wr(UDC_OFS_CONTROL, {28'h0, m[2], 3'b000}, rr);
         axi_wr(UDC_OFS_CONTROL, {28'h0, m[2], m[1], m[0], 1'b1}, rr);
         repeat (2) @(posedge aclk);
         run(20, m[0], m[1], m[2]);
      end
      print_verdict();
   end
endmodule // tb_top
bind udc_up_down_counter udc_monitor mon_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .count_state, .terminal_count_n);
`default_nettype wire
